// ---- jesd_link_test_and_lane_packing.sv ----
/*
  apb-reached control of the serial transmitter: link test patterns, sync request,
  link state sequencing, phase reset steering and lane packing;
  assumes lmfc_edge_i and phase_event_i are one-cycle pulses synchronous to sys_clk_i
*/
// Functional notes
// - test code zero leaves the normal data path untouched on every lane
// - test code one sends D21.5, alternating ones and zeros, on all lanes
// - test code two sends K28.5 comma characters on all lanes
// - test code three repeats the alignment sequence forever once entered from code group sync, never reaching payload
// - test code four sends a repeating 120-bit pseudo-random pattern
// - sync request bit set sends a K28.5 stream asking for reinitialization
// - after the requested K28.5 stream the link restarts initialization
// - two-bit field picks the multiframe edge that starts alignment, default zero
// - mask bit clear: events reset jesd, divider, demodulator and pattern phases
// - mask bit set: events reset only demodulator and pattern generator phases
// - once bit set: only the first event resets all, later ones partial
// - two-octet bit clear packs samples without padding
// - two-octet bit set pads each sample to sixteen bits
// - packing code zero: four converters per lane, four lanes active
// - packing code one: eight converters per lane, two lanes active
// - packing code four: two converters per lane, all eight lanes active
// - alignment disable bit skips the sequence, payload right after sync
`timescale 1ns/1ps
module jesd_link_test_and_lane_packing (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // link timing and events
  input wire logic sync_n_i,
  input wire logic lmfc_edge_i,
  input wire logic phase_event_i,
  // transmit symbol stream
  output logic [1:0] link_phase_o,
  output logic [9:0] tx_word_o,
  output logic test_active_o,
  // lane packing
  output logic [7:0] lane_en_o,
  output logic [3:0] conv_per_lane_o,
  output logic two_octet_o,
  // phase reset pulses
  output logic jesd_phase_rst_o,
  output logic div_phase_rst_o,
  output logic demod_phase_rst_o,
  output logic tpg_phase_rst_o
);
  // configuration registers
  logic [2:0] link_test_select_r;
  logic sync_req_r;
  logic [1:0] alignment_start_edge_r;
  logic phase_reset_mask_b_r;
  logic phase_reset_once_r;
  logic two_octet_sample_r;
  logic [2:0] pack_code_r;
  logic alignment_seq_disable_r;
  // link and reset state
  jesd_link_pkg::link_state_type state_r;
  jesd_link_pkg::link_state_type state_nxt;
  logic [1:0] edge_cnt_r;
  logic [1:0] edge_cnt_nxt;
  logic [1:0] ila_cnt_r;
  logic [1:0] ila_cnt_nxt;
  logic once_armed_r;
  logic once_armed_nxt;
  // bus decode
  logic [9:0] reg_idx;
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic hit_test;
  logic hit_pack;
  logic hit_align;
  logic hit_status;
  logic addr_hit;
  logic [15:0] rd_word;
  logic [15:0] test_word;
  logic [15:0] pack_word;
  logic [15:0] align_word;
  logic [15:0] status_word;
  // datapath
  logic cgs_hold;
  logic start_ila;
  logic ila_done;
  logic full_reset;
  logic arm_write;
  logic [9:0] prbs_word;
  logic [9:0] tx_word_nxt;
  logic [7:0] lane_en_nxt;
  logic [3:0] conv_nxt;
  logic tpg_rst_now;

  // address decode over word indices
  assign reg_idx = paddr_i[11:jesd_link_pkg::IDX_LSB];
  assign hit_test = (reg_idx == jesd_link_pkg::LINK_TEST_IDX);
  assign hit_pack = (reg_idx == jesd_link_pkg::LANE_PACK_IDX);
  assign hit_align = (reg_idx == jesd_link_pkg::ALIGN_CTRL_IDX);
  assign hit_status = (reg_idx == jesd_link_pkg::STATUS_IDX);
  assign addr_hit = hit_test | hit_pack | hit_align | hit_status;
  assign setup_phase = psel_i & ~penable_i;
  assign access_done = psel_i & penable_i & pready_o;
  assign wr_en = access_done & pwrite_i & ~pslverr_o;

  // read views, reserved bits as zero
  assign test_word = {link_test_select_r, sync_req_r, alignment_start_edge_r, 1'b0,
                      phase_reset_mask_b_r, phase_reset_once_r, 7'h00};
  assign pack_word = {7'h00, two_octet_sample_r, pack_code_r, 5'h00};
  assign align_word = {5'h00, alignment_seq_disable_r, 10'h000};
  assign status_word = {13'h0000, once_armed_r, state_r};
  assign rd_word = hit_test ? test_word :
                   hit_pack ? pack_word :
                   hit_align ? align_word :
                   hit_status ? status_word : 16'h0000;

  // one-cycle answer: ready and data loaded in the setup cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup_phase;
      pslverr_o <= setup_phase & ~addr_hit;
      prdata_o <= (setup_phase & ~pwrite_i) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  // software-written configuration
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_test_select_r <= jesd_link_pkg::TEST_RST;
      sync_req_r <= 1'b0;
      alignment_start_edge_r <= jesd_link_pkg::EDGE_RST;
      phase_reset_mask_b_r <= 1'b0;
      phase_reset_once_r <= 1'b0;
      two_octet_sample_r <= 1'b0;
      pack_code_r <= jesd_link_pkg::PACK_RST;
      alignment_seq_disable_r <= 1'b0;
    end else if (wr_en) begin
      if (hit_test) begin
        link_test_select_r <= pwdata_i[jesd_link_pkg::TEST_MSB:jesd_link_pkg::TEST_LSB];
        sync_req_r <= pwdata_i[jesd_link_pkg::SYNC_REQ_BIT];
        alignment_start_edge_r <= pwdata_i[jesd_link_pkg::EDGE_MSB:jesd_link_pkg::EDGE_LSB];
        phase_reset_mask_b_r <= pwdata_i[jesd_link_pkg::MASK_B_BIT];
        phase_reset_once_r <= pwdata_i[jesd_link_pkg::ONCE_BIT];
      end
      if (hit_pack) begin
        two_octet_sample_r <= pwdata_i[jesd_link_pkg::TWO_OCT_BIT];
        pack_code_r <= pwdata_i[jesd_link_pkg::PACK_MSB:jesd_link_pkg::PACK_LSB];
      end
      if (hit_align) begin
        alignment_seq_disable_r <= pwdata_i[jesd_link_pkg::ALIGN_DIS_BIT];
      end
    end
  end

  // sync request or receiver sync low pins the link in code group sync
  assign cgs_hold = sync_req_r | ~sync_n_i;
  assign start_ila = lmfc_edge_i & (edge_cnt_r == alignment_start_edge_r);
  assign ila_done = lmfc_edge_i & (ila_cnt_r == jesd_link_pkg::ILA_LAST_MF)
                    & (link_test_select_r != jesd_link_pkg::TEST_ILA);

  // link state sequencing
  always_comb begin
    state_nxt = state_r;
    edge_cnt_nxt = edge_cnt_r;
    ila_cnt_nxt = ila_cnt_r;
    unique case (state_r)
      jesd_link_pkg::ST_CGS: begin
        ila_cnt_nxt = 2'h0;
        if (cgs_hold) begin
          edge_cnt_nxt = 2'h0;
        end else if (start_ila) begin
          edge_cnt_nxt = 2'h0;
          state_nxt = alignment_seq_disable_r ? jesd_link_pkg::ST_DATA
                                              : jesd_link_pkg::ST_ILA;
        end else if (lmfc_edge_i) begin
          edge_cnt_nxt = 2'(edge_cnt_r + 2'h1);
        end
      end
      jesd_link_pkg::ST_ILA: begin
        if (cgs_hold) begin
          state_nxt = jesd_link_pkg::ST_CGS;
        end else if (ila_done) begin
          state_nxt = jesd_link_pkg::ST_DATA;
        end else if (lmfc_edge_i && link_test_select_r != jesd_link_pkg::TEST_ILA) begin
          ila_cnt_nxt = 2'(ila_cnt_r + 2'h1);
        end
      end
      jesd_link_pkg::ST_DATA: begin
        if (cgs_hold) begin
          state_nxt = jesd_link_pkg::ST_CGS;
        end
      end
      default: begin
        state_nxt = jesd_link_pkg::ST_CGS;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= jesd_link_pkg::ST_CGS;
      edge_cnt_r <= 2'h0;
      ila_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      ila_cnt_r <= ila_cnt_nxt;
    end
  end

  // a write with the once bit high arms the next event; arming wins over use
  assign arm_write = wr_en & hit_test & pwdata_i[jesd_link_pkg::ONCE_BIT];
  assign once_armed_nxt = arm_write ? 1'b1 : (phase_event_i ? 1'b0 : once_armed_r);
  assign full_reset = phase_event_i & ~phase_reset_mask_b_r
                      & (~phase_reset_once_r | once_armed_r);
  assign tpg_rst_now = phase_event_i;

  // phase reset pulses
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      once_armed_r <= 1'b0;
      jesd_phase_rst_o <= 1'b0;
      div_phase_rst_o <= 1'b0;
      demod_phase_rst_o <= 1'b0;
      tpg_phase_rst_o <= 1'b0;
    end else begin
      once_armed_r <= once_armed_nxt;
      jesd_phase_rst_o <= full_reset;
      div_phase_rst_o <= full_reset;
      demod_phase_rst_o <= phase_event_i;
      tpg_phase_rst_o <= tpg_rst_now;
    end
  end

  // pseudo-random source, restarted by the pattern phase reset
  lane_pattern_gen u_pattern (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .en_i(link_test_select_r == jesd_link_pkg::TEST_PRBS),
    .phase_rst_i(tpg_rst_now),
    .word_o(prbs_word)
  );

  // symbol selection: test pattern first, then link state
  assign tx_word_nxt =
    (link_test_select_r == jesd_link_pkg::TEST_D215) ? jesd_link_pkg::SYM_D215 :
    (link_test_select_r == jesd_link_pkg::TEST_K285) ? jesd_link_pkg::SYM_K285 :
    (link_test_select_r == jesd_link_pkg::TEST_PRBS) ? prbs_word :
    (state_r == jesd_link_pkg::ST_CGS) ? jesd_link_pkg::SYM_K285 :
    (state_r == jesd_link_pkg::ST_ILA) ? jesd_link_pkg::SYM_K280 :
    jesd_link_pkg::SYM_IDLE;

  // lane map, invalid codes fall back to four per lane
  assign lane_en_nxt = (pack_code_r == jesd_link_pkg::PACK_EIGHT) ? jesd_link_pkg::LANES_TWO :
                       (pack_code_r == jesd_link_pkg::PACK_TWO) ? jesd_link_pkg::LANES_ALL :
                       jesd_link_pkg::LANES_FOUR;
  assign conv_nxt = (pack_code_r == jesd_link_pkg::PACK_EIGHT) ? jesd_link_pkg::CONV_EIGHT :
                    (pack_code_r == jesd_link_pkg::PACK_TWO) ? jesd_link_pkg::CONV_TWO :
                    jesd_link_pkg::CONV_FOUR;

  // registered stream and packing outputs
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_word_o <= jesd_link_pkg::SYM_K285;
      link_phase_o <= 2'h0;
      test_active_o <= 1'b0;
      lane_en_o <= jesd_link_pkg::LANES_FOUR;
      conv_per_lane_o <= jesd_link_pkg::CONV_FOUR;
      two_octet_o <= 1'b0;
    end else begin
      tx_word_o <= tx_word_nxt;
      link_phase_o <= state_r;
      test_active_o <= (link_test_select_r != jesd_link_pkg::TEST_NORMAL);
      lane_en_o <= lane_en_nxt;
      conv_per_lane_o <= conv_nxt;
      two_octet_o <= two_octet_sample_r;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_armed_event;
    phase_event_i && phase_reset_once_r && once_armed_r && !phase_reset_mask_b_r && !arm_write;
  endsequence
  sequence s_all_reset;
    jesd_phase_rst_o && div_phase_rst_o && demod_phase_rst_o && tpg_phase_rst_o;
  endsequence

  a_d215_stream: assert property (
    link_test_select_r == jesd_link_pkg::TEST_D215 |=> tx_word_o == 10'h2AA)
    else $error("d21.5 test word missing");
  a_k285_stream: assert property (
    link_test_select_r == jesd_link_pkg::TEST_K285 |=> tx_word_o == 10'h0FA)
    else $error("k28.5 test word missing");
  a_ila_forever: assert property (
    state_r == jesd_link_pkg::ST_ILA && link_test_select_r == jesd_link_pkg::TEST_ILA
    && sync_n_i && !sync_req_r |=> state_r == jesd_link_pkg::ST_ILA)
    else $error("alignment sequence left under its test code");
  a_sync_req_cgs: assert property (
    sync_req_r && link_test_select_r == jesd_link_pkg::TEST_NORMAL
    |=> state_r == jesd_link_pkg::ST_CGS ##1 tx_word_o == 10'h0FA)
    else $error("sync request did not hold code group sync");
  a_normal_data: assert property (
    link_test_select_r == jesd_link_pkg::TEST_NORMAL && state_r == jesd_link_pkg::ST_DATA
    |=> tx_word_o == 10'h000 && !test_active_o)
    else $error("normal data path altered");
  a_ila_skip: assert property (
    state_r == jesd_link_pkg::ST_CGS && start_ila && !cgs_hold && alignment_seq_disable_r
    |=> state_r == jesd_link_pkg::ST_DATA)
    else $error("disabled alignment sequence not skipped");
  a_full_reset: assert property (
    phase_event_i && !phase_reset_mask_b_r && !phase_reset_once_r |=> s_all_reset)
    else $error("event did not reset all phases");
  a_mask_partial: assert property (
    phase_event_i && phase_reset_mask_b_r
    |=> !jesd_phase_rst_o && !div_phase_rst_o && demod_phase_rst_o && tpg_phase_rst_o)
    else $error("masked event reset wrong blocks");
  a_once_first: assert property (
    s_armed_event |=> s_all_reset and !once_armed_r)
    else $error("first event after arming not a full reset");
  a_once_later: assert property (
    phase_event_i && phase_reset_once_r && !once_armed_r
    |=> !jesd_phase_rst_o && demod_phase_rst_o)
    else $error("later event reset jesd phase");
  a_lane_map: assert property (
    pack_code_r == jesd_link_pkg::PACK_EIGHT |=> lane_en_o == 8'h03 && conv_per_lane_o == 4'h8)
    else $error("eight per lane map wrong");
  a_two_octet: assert property (
    ##1 two_octet_o == $past(two_octet_sample_r))
    else $error("two-octet output does not follow its bit");
endmodule // jesd_link_test_and_lane_packing

// ---- jesd_link_pkg.sv ----
/*
  constants, field layouts and state codes shared by the link test and lane packing block;
  assumes a 16-bit register view carried in the low half of a 32-bit apb word
*/
package jesd_link_pkg;
  // register indices, byte address is four times the index
  localparam logic [9:0] ALIGN_CTRL_IDX = 10'h049;
  localparam logic [9:0] LINK_TEST_IDX = 10'h04A;
  localparam logic [9:0] LANE_PACK_IDX = 10'h04B;
  localparam logic [9:0] STATUS_IDX = 10'h04C;
  localparam int IDX_LSB = 2;
  // link_test_reset_control fields
  localparam int TEST_MSB = 15;
  localparam int TEST_LSB = 13;
  localparam int SYNC_REQ_BIT = 12;
  localparam int EDGE_MSB = 11;
  localparam int EDGE_LSB = 10;
  localparam int MASK_B_BIT = 8;
  localparam int ONCE_BIT = 7;
  // lane_packing_config fields
  localparam int TWO_OCT_BIT = 8;
  localparam int PACK_MSB = 7;
  localparam int PACK_LSB = 5;
  // alignment control field
  localparam int ALIGN_DIS_BIT = 10;
  // reset values
  localparam logic [2:0] TEST_RST = 3'h0;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [2:0] PACK_RST = 3'h0;
  // link test codes
  localparam logic [2:0] TEST_NORMAL = 3'h0;
  localparam logic [2:0] TEST_D215 = 3'h1;
  localparam logic [2:0] TEST_K285 = 3'h2;
  localparam logic [2:0] TEST_ILA = 3'h3;
  localparam logic [2:0] TEST_PRBS = 3'h4;
  // lane packing codes and results
  localparam logic [2:0] PACK_FOUR = 3'h0;
  localparam logic [2:0] PACK_EIGHT = 3'h1;
  localparam logic [2:0] PACK_TWO = 3'h4;
  localparam logic [7:0] LANES_FOUR = 8'h0F;
  localparam logic [7:0] LANES_TWO = 8'h03;
  localparam logic [7:0] LANES_ALL = 8'hFF;
  localparam logic [3:0] CONV_FOUR = 4'h4;
  localparam logic [3:0] CONV_EIGHT = 4'h8;
  localparam logic [3:0] CONV_TWO = 4'h2;
  // ten-bit coded symbols
  localparam logic [9:0] SYM_D215 = 10'h2AA;
  localparam logic [9:0] SYM_K285 = 10'h0FA;
  localparam logic [9:0] SYM_K280 = 10'h0F4;
  localparam logic [9:0] SYM_IDLE = 10'h000;
  // alignment sequence length in multiframes, minus one
  localparam logic [1:0] ILA_LAST_MF = 2'h3;
  // pseudo-random pattern: 120 bits sent as twelve ten-bit words
  localparam int WORD_BITS = 10;
  localparam int PRBS_BITS = 120;
  localparam logic [3:0] PRBS_LAST_WORD = 4'(PRBS_BITS / WORD_BITS - 1);
  localparam logic [6:0] PRBS_SEED = 7'h7F;
  // link states, gray coded along cgs, ila, data
  typedef enum logic [1:0] {
    ST_CGS = 2'h0,
    ST_ILA = 2'h1,
    ST_DATA = 2'h3
  } link_state_type;
endpackage

// ---- lane_pattern_gen.sv ----
/*
  repeating 120-bit pseudo-random word source, ten bits per clock;
  assumes the caller restarts it through phase_rst_i or by dropping en_i
*/
`timescale 1ns/1ps
module lane_pattern_gen (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // control
  input wire logic en_i,
  input wire logic phase_rst_i,
  // pattern
  output logic [9:0] word_o
);
  logic [6:0] lfsr_r;
  logic [6:0] lfsr_nxt;
  logic [3:0] word_cnt_r;
  logic [3:0] word_cnt_nxt;
  logic wrap;

  // ten steps of x^7 + x^6 + 1 per word
  always_comb begin
    lfsr_nxt = lfsr_r;
    word_o = '0;
    for (int i = 0; i < jesd_link_pkg::WORD_BITS; i++) begin
      word_o[jesd_link_pkg::WORD_BITS - 1 - i] = lfsr_nxt[6];
      lfsr_nxt = {lfsr_nxt[5:0], lfsr_nxt[6] ^ lfsr_nxt[5]};
    end
  end

  // reseed after twelve words so the period is exactly 120 bits
  assign wrap = (word_cnt_r == jesd_link_pkg::PRBS_LAST_WORD);
  assign word_cnt_nxt = wrap ? 4'h0 : 4'(word_cnt_r + 4'h1);

  // state advances only while the pattern is selected
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lfsr_r <= jesd_link_pkg::PRBS_SEED;
      word_cnt_r <= 4'h0;
    end else if (!en_i || phase_rst_i || wrap) begin
      lfsr_r <= jesd_link_pkg::PRBS_SEED;
      word_cnt_r <= (en_i && !phase_rst_i) ? word_cnt_nxt : 4'h0;
    end else begin
      lfsr_r <= lfsr_nxt;
      word_cnt_r <= word_cnt_nxt;
    end
  end
endmodule // lane_pattern_gen

// ---- jesd_rx_model.sv ----
/*
  receiver-side stand-in: code group sync request line and multiframe edges;
  assumes the bench decides when code group sync is held
*/
`timescale 1ns/1ps
module jesd_rx_model #(
  parameter int LMFC_PERIOD = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // control from bench
  input wire logic hold_sync_i,
  // link timing
  output logic sync_n_o,
  output logic lmfc_edge_o
);
  logic [7:0] cnt_r;

  // free running multiframe counter, one pulse per period, sync line registered
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
      lmfc_edge_o <= 1'b0;
      sync_n_o <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 8'(LMFC_PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
      lmfc_edge_o <= (cnt_r == 8'h00);
      sync_n_o <= ~hold_sync_i; // low keeps the transmitter in code group sync
    end
  end
endmodule // jesd_rx_model

// ---- tb_jesd_link_test_and_lane_packing.sv ----
/*
  self-checking bench: apb register access, lane packing, link bring-up, test patterns,
  sync request and phase reset steering; assumes the receiver model beside it
*/
`timescale 1ns/1ps
module tb_jesd_link_test_and_lane_packing;
  localparam logic [9:0] LT = jesd_link_pkg::LINK_TEST_IDX;
  localparam logic [9:0] LP = jesd_link_pkg::LANE_PACK_IDX;
  localparam logic [9:0] AC = jesd_link_pkg::ALIGN_CTRL_IDX;
  localparam logic [1:0] CGS = jesd_link_pkg::ST_CGS;
  localparam logic [1:0] ILA = jesd_link_pkg::ST_ILA;
  localparam logic [1:0] DAT = jesd_link_pkg::ST_DATA;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic hold = 1'b1;
  logic ev = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sync_n, lmfc, tact, toct, jr, dr, mr, tr;
  logic [1:0] ph;
  logic [9:0] txw;
  logic [7:0] lanes;
  logic [3:0] conv;
  logic [9:0] w [0:23];
  logic [2:0] pc [0:2] = '{3'h0, 3'h1, 3'h4};
  logic [7:0] el [0:2] = '{8'h0F, 8'h03, 8'hFF};
  logic [3:0] ec [0:2] = '{4'h4, 4'h8, 4'h2};
  logic ok;
  int n_mismatch = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // device and receiver model
  jesd_link_test_and_lane_packing jesd_link_test_and_lane_packing_i (
    .sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sync_n_i(sync_n), .lmfc_edge_i(lmfc), .phase_event_i(ev),
    .link_phase_o(ph), .tx_word_o(txw), .test_active_o(tact), .lane_en_o(lanes),
    .conv_per_lane_o(conv), .two_octet_o(toct), .jesd_phase_rst_o(jr),
    .div_phase_rst_o(dr), .demod_phase_rst_o(mr), .tpg_phase_rst_o(tr));
  jesd_rx_model jesd_rx_model_i (
    .sys_clk_i(clk), .rstn_i(rstn), .hold_sync_i(hold), .sync_n_o(sync_n),
    .lmfc_edge_o(lmfc));

  // verdict and end of run
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one comparison
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  // bounded wait failure
  task hang(input string nm);
    $display("Error %s expected done seen timeout", nm);
    n_mismatch++;
    conclude();
  endtask

  // one apb transfer, entered and left just after a rising edge
  task apb(input logic w_i, input logic [9:0] idx, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w_i;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [9:0] idx, input logic [15:0] d);
    apb(1'b1, idx, {16'h0000, d});
  endtask

  task rdchk(input string nm, input logic [9:0] idx, input logic [31:0] exp, input logic e);
    apb(1'b0, idx, 32'h00000000);
    chk(nm, exp, rd);
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // wait for n multiframe edges, bounded
  task edges(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (lmfc !== 1'b1 && k < 100);
      if (k >= 100) hang("lmfc_edge");
    end
  endtask

  // restart the link and follow it out of code group sync
  task up(input logic [2:0] code, input logic [1:0] n, input logic dis);
    wr(AC, {5'h00, dis, 10'h000});
    wr(LT, {code, 1'b0, n, 10'h000});
    hold <= 1'b1;
    tick(4);
    edges(1);
    hold <= 1'b0;
    if (n > 0) edges(int'(n));
    tick(2);
    chk("phase_before_edge", 32'(CGS), 32'(ph));
    edges(1);
    tick(2);
    chk("phase_entry", dis ? 32'(DAT) : 32'(ILA), 32'(ph));
  endtask

  // one phase event, pulses one cycle later for one cycle
  task evt(input logic [3:0] exp);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    @(posedge clk);
    chk("phase_rst", 32'(exp), 32'({jr, dr, mr, tr}));
    @(posedge clk);
    chk("phase_rst_end", 32'h0, 32'({jr, dr, mr, tr}));
  endtask

  // main sequence
  initial begin
    tick(15);
    chk("rst_lanes", 32'h0F, 32'(lanes));
    chk("rst_conv", 32'h4, 32'(conv));
    chk("rst_word", 32'h0FA, 32'(txw));
    chk("rst_phase", 32'(CGS), 32'(ph));
    tick(1);
    rstn <= 1'b1;
    tick(1);
    rdchk("test_reg", LT, 32'h0, 1'b0);
    rdchk("pack_reg", LP, 32'h0, 1'b0);
    rdchk("align_reg", AC, 32'h0, 1'b0);
    rdchk("unmapped", 10'h010, 32'h0, 1'b1);
    apb(1'b1, LT, 32'hFFFF0D00);
    rdchk("test_rw", LT, 32'h00000D00, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(LP, {7'h00, i[0], pc[i], 5'h00});
      tick(2);
      chk("lane_en", 32'(el[i]), 32'(lanes));
      chk("conv", 32'(ec[i]), 32'(conv));
      chk("two_octet", 32'(i[0]), 32'(toct));
      rdchk("pack_rb", LP, {23'h0, i[0], pc[i], 5'h00}, 1'b0);
    end
    $display("test packing done");
    up(3'h0, 2'h0, 1'b0);
    edges(3);
    tick(2);
    chk("phase_ila", 32'(ILA), 32'(ph));
    edges(1);
    tick(2);
    chk("phase_data", 32'(DAT), 32'(ph));
    chk("normal_word", 32'h000, 32'(txw));
    chk("normal_test", 32'h0, 32'(tact));
    up(3'h0, 2'h3, 1'b1);
    wr(AC, 16'h0000); // alignment sequence back on for the resync test
    $display("test bringup done");
    wr(LT, 16'h2000);
    tick(3);
    chk("d215", 32'h2AA, 32'(txw));
    chk("test_on", 32'h1, 32'(tact));
    wr(LT, 16'h4000);
    tick(3);
    chk("k285", 32'h0FA, 32'(txw));
    wr(LT, 16'h8000);
    tick(3);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      w[i] = txw;
    end
    for (int i = 0; i < 12; i++) chk("prbs_repeat", 32'(w[i]), 32'(w[i + 12]));
    foreach (ec[p]) begin
      ok = 1'b0;
      for (int i = 0; i < 12; i++) if (w[i] !== w[i + 2 * p + 1]) ok = 1'b1;
      chk("prbs_short", 32'h1, 32'(ok));
    end
    wr(LT, 16'h0000);
    tick(3);
    chk("back_normal", 32'h000, 32'(txw));
    $display("test patterns done");
    wr(LT, 16'h1000);
    tick(2);
    chk("syncreq_phase", 32'(CGS), 32'(ph));
    chk("syncreq_word", 32'h0FA, 32'(txw));
    edges(2);
    tick(2);
    chk("syncreq_hold", 32'(CGS), 32'(ph));
    edges(1);
    wr(LT, 16'h0000);
    edges(1);
    tick(2);
    chk("reinit_ila", 32'(ILA), 32'(ph));
    up(3'h3, 2'h0, 1'b0);
    edges(6);
    tick(2);
    chk("ila_forever", 32'(ILA), 32'(ph));
    $display("test sync done");
    wr(LT, 16'h0000);
    evt(4'hF);
    wr(LT, 16'h0100);
    evt(4'h3);
    wr(LT, 16'h0080);
    evt(4'hF);
    evt(4'h3);
    $display("test phase reset done");
    conclude();
  end
endmodule // tb_jesd_link_test_and_lane_packing
